// >>> logic/dtpf_framer.sv
// downstream transport packet framer: byte stream of 188-byte packets
`timescale 1ns/1ns
`include "dtpf_cfg.svh"

module dtpf_framer #(
  parameter int POS_W = `DTPF_POS_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // control
  input wire logic interleave_en_i,
  // MAC byte stream
  input wire logic [7:0] mac_data_i,
  input wire logic mac_valid_i,
  input wire logic mac_eof_i,
  output logic mac_ready_o,
  // other service packets, offered whole
  input wire logic other_avail_i,
  input wire logic [7:0] other_data_i,
  output logic other_ready_o,
  // transport stream toward the modulator
  output logic [7:0] ts_data_o,
  output logic ts_valid_o,
  output logic ts_sop_o,
  output dtpf_pkg::dtpf_kind_type ts_kind_o
);
  import dtpf_pkg::*;

  // the identifier is split across two header bytes
  localparam logic [12:0] DOC_ID = `DTPF_PID;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] next_pos;
  dtpf_kind_type kind;
  dtpf_kind_type next_kind;
  logic pusi;
  logic next_pusi;
  logic in_frame;
  logic next_in_frame;
  logic next_mac_ready;
  logic next_other_ready;
  logic take_mac;
  logic [7:0] next_byte;
  logic [`DTPF_CC_W-1:0] cc;
  logic cc_step;
  logic last_slot;
  logic [POS_W-1:0] first_open;

  // helpers read only by the checks below
  logic [POS_W-1:0] out_pos;
  logic out_mac;
  logic seen_sop;

  assign last_slot = (pos == `DTPF_LAST_POS);
  assign take_mac = mac_ready_o && mac_valid_i;

  // ---------------------------------------------------------------
  // continuity counter
  // ---------------------------------------------------------------
  // step once the header byte carrying the count has been formed
  assign cc_step = (kind == KIND_DOC) && (pos == `DTPF_POS_HDR3);

  dtpf_cc_counter #(
    .CC_W(`DTPF_CC_W)
  ) u_cc (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .step_i(cc_step),
    .count_o(cc)
  );

  // ---------------------------------------------------------------
  // byte selection for the current slot
  // ---------------------------------------------------------------
  // other-service bytes pass through untouched, header and all
  always_comb begin
    next_byte = `DTPF_STUFF;
    if (kind == KIND_OTHER) begin
      next_byte = other_data_i;
    end else begin
      case (pos)
        `DTPF_POS_SYNC: begin
          next_byte = `DTPF_SYNC;
        end
        `DTPF_POS_HDR1: begin
          next_byte = {`DTPF_TEI, pusi, `DTPF_PRIO,
                       DOC_ID[12:8]};
        end
        `DTPF_POS_HDR2: begin
          next_byte = DOC_ID[7:0];
        end
        `DTPF_POS_HDR3: begin
          next_byte = {`DTPF_SCR, `DTPF_AFC, cc};
        end
        default: begin
          if (pusi && pos == `DTPF_POS_PTR) begin
            // frames only start in pointer packets, and only after
            // the pointer, so nothing ever needs skipping
            next_byte = `DTPF_PTR_ZERO;
          end else if (take_mac) begin
            next_byte = mac_data_i;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // next slot bookkeeping
  // ---------------------------------------------------------------
  always_comb begin
    next_pos = last_slot ? `DTPF_POS_SYNC : pos + 8'd1;
    next_in_frame = in_frame;
    if (take_mac) begin
      next_in_frame = !mac_eof_i;
    end
    next_kind = kind;
    next_pusi = pusi;
    if (last_slot) begin
      // other service only at a boundary; a MAC frame may straddle it
      if (interleave_en_i && other_avail_i) begin
        next_kind = KIND_OTHER;
      end else begin
        next_kind = KIND_DOC;
      end
      // a packet that opens mid-frame carries no pointer and admits
      // no new frame; wasteful on the tail but needs no lookahead
      next_pusi = !next_in_frame;
    end
  end

  // first payload slot of the next packet, after any pointer
  assign first_open = next_pusi ? `DTPF_POS_BODY : `DTPF_POS_PTR;

  // grants are registered so ready comes from a flop
  always_comb begin
    next_mac_ready = (next_kind == KIND_DOC) && (next_pos >= first_open)
                     && (next_pusi || next_in_frame);
    next_other_ready = (next_kind == KIND_OTHER);
  end

  // ---------------------------------------------------------------
  // slot state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pos <= `DTPF_POS_SYNC;
      kind <= KIND_DOC;
      pusi <= 1'b1;
    end else begin
      pos <= next_pos;
      kind <= next_kind;
      pusi <= next_pusi;
    end
  end

  // MAC frame tracking, one bit: are we inside a frame
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= next_in_frame;
    end
  end

  // source grants
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mac_ready_o <= 1'b0;
      other_ready_o <= 1'b0;
    end else begin
      mac_ready_o <= next_mac_ready;
      other_ready_o <= next_other_ready;
    end
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  // a MAC underrun mid-frame still emits stuffing so the stream never
  // breaks; the MAC side must keep valid up within a frame
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ts_data_o <= `DTPF_STUFF;
      ts_valid_o <= 1'b0;
      ts_sop_o <= 1'b0;
      ts_kind_o <= KIND_DOC;
    end else begin
      ts_data_o <= next_byte;
      ts_valid_o <= 1'b1;
      ts_sop_o <= (pos == `DTPF_POS_SYNC);
      ts_kind_o <= kind;
    end
  end

  // check helpers
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      out_pos <= `DTPF_POS_SYNC;
      out_mac <= 1'b0;
      seen_sop <= 1'b0;
    end else begin
      out_pos <= pos;
      out_mac <= take_mac;
      if (ts_sop_o) begin
        seen_sop <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking fr_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  // stream shape
  a_sync_first: assert property (ts_sop_o |-> ts_data_o == `DTPF_SYNC)
    else $error("packet does not open with sync byte");

  a_pkt_length: assert property (ts_sop_o && seen_sop
                  |-> $past(out_pos) == `DTPF_LAST_POS)
    else $error("packet length is not 188 bytes");

  a_no_gap: assert property ($past(ts_valid_o) |-> ts_valid_o)
    else $error("gap in transport stream");

  // fixed header fields on cable data packets
  a_flags_zero: assert property (ts_sop_o && ts_kind_o == KIND_DOC
                  |=> !ts_data_o[7] && !ts_data_o[5])
    else $error("error or priority bit not zero");

  a_pid_value: assert property (ts_sop_o && ts_kind_o == KIND_DOC
                 |=> ts_data_o[4:0] == DOC_ID[12:8]
                 ##1 ts_data_o == DOC_ID[7:0])
    else $error("wrong PID on cable data packet");

  a_ctrl_fields: assert property (ts_sop_o && ts_kind_o == KIND_DOC
                   |=> ##2 ts_data_o[7:4] == {`DTPF_SCR, `DTPF_AFC})
    else $error("scrambling or adaptation control wrong");

  a_pointer_byte: assert property (ts_sop_o && ts_kind_o == KIND_DOC
                    ##1 ts_data_o[6] |-> ##3 ts_data_o == `DTPF_PTR_ZERO)
    else $error("pointer byte missing after start indicator");

  // source grants against the slot map
  a_payload_start: assert property (mac_ready_o
                     |-> pos >= `DTPF_POS_PTR && kind == KIND_DOC)
    else $error("MAC byte granted inside header");

  a_stuff_fill: assert property (ts_kind_o == KIND_DOC && !out_mac
                  && out_pos >= `DTPF_POS_BODY
                  |-> ts_data_o == `DTPF_STUFF)
    else $error("idle payload byte is not stuffing");

  a_other_whole: assert property (ts_sop_o && ts_kind_o == KIND_OTHER
                   |-> $past(other_ready_o) && !$past(mac_ready_o))
    else $error("other service packet not granted at its start");

  a_grant_excl: assert property (mac_ready_o |-> !other_ready_o)
    else $error("both sources granted in one slot");

  a_other_grant: assert property (other_ready_o |-> kind == KIND_OTHER)
    else $error("other service granted outside its packet");

  a_no_late_start: assert property (take_mac && mac_eof_i && !pusi
                     |=> !mac_ready_o)
    else $error("new frame granted in a packet without pointer");

  a_pointer_slot: assert property (mac_ready_o && pusi
                    |-> pos >= `DTPF_POS_BODY)
    else $error("MAC byte granted over the pointer field");

  // packet-level consistency: kind and indicator only move at a boundary
  a_kind_steady: assert property (!ts_sop_o |-> $stable(ts_kind_o))
    else $error("packet kind changed inside a packet");

  a_pusi_boundary: assert property (!$past(last_slot) |-> $stable(pusi))
    else $error("start indicator changed inside a packet");

endmodule

// >>> logic/dtpf_cfg.svh
// constants for the downstream transport packet framer
`ifndef DTPF_CFG_SVH
`define DTPF_CFG_SVH

// packet geometry, in bytes
`define DTPF_PKT_LEN 188
`define DTPF_HDR_LEN 4
`define DTPF_POS_W 8
`define DTPF_LAST_POS 8'd187
`define DTPF_POS_SYNC 8'd0
`define DTPF_POS_HDR1 8'd1
`define DTPF_POS_HDR2 8'd2
`define DTPF_POS_HDR3 8'd3
`define DTPF_POS_PTR 8'd4
`define DTPF_POS_BODY 8'd5

// fixed header field values on the cable data identifier
`define DTPF_SYNC 8'h47
`define DTPF_PID 13'h1ffe
`define DTPF_TEI 1'h0
`define DTPF_PRIO 1'h0
`define DTPF_SCR 2'h0
`define DTPF_AFC 2'h1

// payload values
`define DTPF_STUFF 8'hff
`define DTPF_PTR_ZERO 8'h00

// continuity counter
`define DTPF_CC_W 4
`define DTPF_CC_RESET 4'h0
`define DTPF_CC_STEP 4'h1

`endif

// >>> logic/dtpf_pkg.sv
// types shared by the downstream transport packet framer
package dtpf_pkg;

  // kind of packet in the current 188-byte slot
  typedef enum logic [1:0] {
    KIND_DOC = 2'b01,
    KIND_OTHER = 2'b10
  } dtpf_kind_type;

endpackage

// >>> logic/dtpf_cc_counter.sv
// continuity counter for packets on the cable data identifier
`timescale 1ns/1ns
`include "dtpf_cfg.svh"

module dtpf_cc_counter #(
  parameter int CC_W = `DTPF_CC_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // step request, one pulse per cable data packet
  input wire logic step_i,
  // current count
  output logic [CC_W-1:0] count_o
);

  // wraps modulo sixteen on its own; no other identifier touches it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_o <= `DTPF_CC_RESET;
    end else if (step_i) begin
      count_o <= count_o + `DTPF_CC_STEP;
    end
  end

  default clocking cc_cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_cc_step: assert property (step_i
               |=> count_o == $past(count_o) + `DTPF_CC_STEP)
    else $error("continuity counter did not advance by one");

  a_cc_hold: assert property (!step_i |=> count_o == $past(count_o))
    else $error("continuity counter moved without a packet");

endmodule

// >>> dv/dtpf_rx_model.sv
// receiving-side model that parses the framed transport stream
`timescale 1ns/1ns
module dtpf_rx_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // transport stream from the framer
  input wire logic [7:0] ts_data_i,
  input wire logic ts_valid_i,
  input wire logic ts_sop_i,
  input wire dtpf_pkg::dtpf_kind_type ts_kind_i,
  // counts seen so far
  output int bad_o,
  output int doc_o,
  output int other_o,
  // packet alignment as the receiver would declare it
  output logic locked_o
);
  import dtpf_pkg::*;
  int pos;
  int cur;
  logic [7:0] hdr1;
  logic [3:0] cc_exp;
  int apos;
  int good_run;
  int bad_run;
  // -------------------------------------------------
  // header parse
  // -------------------------------------------------
  // blocking updates: the model samples settled registers at each edge
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pos = -1;
      bad_o = 0;
      doc_o = 0;
      other_o = 0;
      cc_exp = 4'h0;
      apos = -1;
      good_run = 0;
      bad_run = 0;
      locked_o = 1'b0;
    end else if (ts_valid_i) begin
      cur = ts_sop_i ? 0 : pos + 1;
      if (pos >= 0 && (ts_sop_i !== (pos == 187))) bad_o++;
      pos = cur;
      // alignment runs on its own 188-byte count once locked; while
      // searching it takes its phase from the packet start
      if (!locked_o && ts_sop_i) apos = 0;
      else apos = (apos < 0 || apos == 187) ? 0 : apos + 1;
      if (apos == 0) begin
        if (ts_data_i === 8'h47) begin
          good_run++;
          bad_run = 0;
        end else begin
          bad_run++;
          good_run = 0;
        end
        if (good_run >= 5) locked_o = 1'b1;
        if (bad_run >= 9) locked_o = 1'b0;
      end
      // other kinds are counted but never parsed as cable data
      if (cur == 0 && ts_kind_i === KIND_OTHER) other_o++;
      if (ts_kind_i === KIND_DOC) begin
        case (cur)
          0: begin
            doc_o++;
            if (ts_data_i !== 8'h47) bad_o++;
          end
          1: begin
            hdr1 = ts_data_i;
            if (ts_data_i[7] !== 1'b0) bad_o++;
            if (ts_data_i[5] !== 1'b0) bad_o++;
          end
          2: if ({hdr1[4:0], ts_data_i} !== 13'h1ffe) bad_o++;
          3: begin
            if (ts_data_i[7:4] !== 4'h1) bad_o++;
            if (ts_data_i[3:0] !== cc_exp) bad_o++;
            cc_exp = ts_data_i[3:0] + 4'h1;
          end
          4: if (hdr1[6] && ts_data_i !== 8'h00) bad_o++;
          default: ;
        endcase
      end
    end else if (pos >= 0) begin
      bad_o++;
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench for the transport packet framer
`timescale 1ns/1ns
module tb;
  import dtpf_pkg::*;
  logic core_clk_i, reset_i, interleave_en_i;
  logic mac_valid_i, mac_eof_i, other_avail_i, mac_ready_o;
  logic [7:0] mac_data_i, other_data_i, ts_data_o;
  logic other_ready_o, ts_valid_o, ts_sop_o;
  dtpf_kind_type ts_kind_o;
  int n_fail, samples_checked, bad, docs, others;
  logic locked;
  dtpf_framer uut (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .interleave_en_i(interleave_en_i), .mac_data_i(mac_data_i),
    .mac_valid_i(mac_valid_i), .mac_eof_i(mac_eof_i),
    .mac_ready_o(mac_ready_o), .other_avail_i(other_avail_i),
    .other_data_i(other_data_i), .other_ready_o(other_ready_o),
    .ts_data_o(ts_data_o), .ts_valid_o(ts_valid_o), .ts_sop_o(ts_sop_o),
    .ts_kind_o(ts_kind_o));
  dtpf_rx_model rx (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .ts_data_i(ts_data_o), .ts_valid_i(ts_valid_o), .ts_sop_i(ts_sop_o),
    .ts_kind_i(ts_kind_o), .bad_o(bad), .doc_o(docs), .other_o(others),
    .locked_o(locked));
  // 50 MHz byte clock
  initial begin
    core_clk_i = 0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset values, then the first header and pointer byte
  task automatic test_reset;
    logic [7:0] hdr [5];
    hdr = '{8'h47, 8'h5f, 8'hfe, 8'h10, 8'h00};
    repeat (4) @(negedge core_clk_i);
    check(ts_data_o, 8'hff);
    check({4'h0, other_ready_o, ts_sop_o, ts_valid_o, mac_ready_o},
      8'h00);
    check({6'h0, ts_kind_o}, 8'h01);
    reset_i = 0;
    for (int k = 0; k < 5; k++) begin
      @(negedge core_clk_i);
      check(ts_data_o, hdr[k]);
      check({7'h0, ts_sop_o}, {7'h0, k == 0});
    end
    check({7'h0, mac_ready_o}, 8'h01);
    $display("test_reset done");
  endtask
  // one MAC frame; the byte seen after each grant, then stuffing
  task automatic test_frame(input int len);
    int i;
    int guard;
    logic took;
    logic last_sop;
    logic [7:0] prev;
    i = 0;
    took = 0;
    guard = 0;
    last_sop = 0;
    while ((i < len || took) && guard < 2000) begin
      @(negedge core_clk_i);
      guard++;
      if (took) check(ts_data_o, prev);
      // a packet opened mid-frame carries no pointer
      if (last_sop && i > 0 && i < len) check(ts_data_o & 8'h40, 8'h00);
      last_sop = ts_sop_o;
      took = 0;
      mac_valid_i = i < len;
      mac_eof_i = i == len - 1;
      mac_data_i = 8'(i * 7 + 3);
      if (i < len && mac_ready_o) begin
        took = 1;
        prev = mac_data_i;
        i++;
      end
    end
    check(8'(guard < 2000), 8'h01);
    for (int k = 0; k < 200; k++) begin
      @(negedge core_clk_i);
      if (ts_sop_o) break;
      check(ts_data_o, 8'hff);
    end
    $display("test_frame %0d done", len);
  endtask
  // other service packets offered for 500 cycles
  task automatic test_interleave(input logic en);
    int n;
    int base;
    logic took;
    logic [7:0] prev;
    logic [7:0] cnt;
    base = others;
    took = 0;
    n = 0;
    cnt = 8'h00;
    interleave_en_i = en;
    for (int k = 0; k < 1000; k++) begin
      @(negedge core_clk_i);
      if (took) check(ts_data_o, prev);
      if (took) check({6'h0, ts_kind_o}, {6'h0, KIND_OTHER});
      other_avail_i = k < 500;
      took = other_ready_o;
      // the other source hands over whole packets, sync byte first
      other_data_i = (n % 188 == 0) ? 8'h47 : cnt;
      prev = other_data_i;
      if (took) begin
        cnt++;
        n++;
      end
    end
    check(8'(n / 188 >= 2), {7'h0, en});
    check(8'(n % 188), 8'h00);
    check(8'(others - base), 8'(n / 188));
    $display("test_interleave %0d done", en);
  endtask
  initial begin
    n_fail = 0;
    samples_checked = 0;
    reset_i = 1;
    interleave_en_i = 0;
    mac_valid_i = 0;
    mac_eof_i = 0;
    mac_data_i = 8'h00;
    other_avail_i = 0;
    other_data_i = 8'h00;
    test_reset();
    test_frame(20);
    test_frame(400);
    test_interleave(1'b0);
    test_interleave(1'b1);
    repeat (400) @(negedge core_clk_i);
    check(8'(bad), 8'h00);
    check(8'(docs > 6), 8'h01);
    check({7'h0, locked}, 8'h01);
    stop_test();
  end
  // watchdog well past the expected 3000 cycles
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
endmodule
